// file: led_regs_pkg.sv
package led_regs_pkg;

    // Serial frame: one command byte, then one data byte
    localparam int unsigned FRAME_BITS   = 16;
    localparam int unsigned CMD_BITS     = 8;
    localparam logic [4:0]  CMD_LAST_BIT = 5'h07;
    localparam logic [4:0]  DATA_LAST_BIT = 5'h0f;
    localparam logic [4:0]  FRAME_END    = 5'h10;
    localparam int unsigned CMD_WRITE_POS = 7;

    // Register offsets
    localparam logic [6:0] ADDR_WHEEL_LOW  = 7'h1b;
    localparam logic [6:0] ADDR_WHEEL_HIGH = 7'h1c;
    localparam logic [6:0] ADDR_BANDWIDTH  = 7'h25;
    localparam logic [6:0] ADDR_CAPABILITY = 7'h26;
    localparam logic [6:0] ADDR_PG_STATUS  = 7'h27;
    localparam logic [6:0] ADDR_OV_STATUS  = 7'h28;

    // Reset values
    localparam logic [7:0] WHEEL_LOW_RESET  = 8'h00;
    localparam logic [7:0] WHEEL_HIGH_RESET = 8'h00;
    localparam logic [3:0] BANDWIDTH_RESET  = 4'h0;
    localparam logic [7:0] CAPABILITY_RESET = 8'hdf;
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // Bandwidth selector fields
    localparam int unsigned BW_ONE_LSB = 2;
    localparam int unsigned BW_TWO_LSB = 0;
    localparam int unsigned BW_WIDTH   = 2;

    // Capability bit positions
    localparam int unsigned CAP_AUTO_LED_OFF_POS   = 7;
    localparam int unsigned CAP_EXT_SWITCH_POS     = 6;
    localparam int unsigned CAP_WHEEL_POS          = 5;
    localparam int unsigned CAP_REG_ONE_MIRROR_POS = 3;
    localparam int unsigned CAP_REG_TWO_MIRROR_POS = 2;
    localparam int unsigned CAP_MIRROR_CONV_ONE_POS = 1;
    localparam int unsigned CAP_MIRROR_CONV_TWO_POS = 0;

    // Status bit positions; power-good and overvoltage share a layout
    localparam int unsigned ST_FOCUS_POS     = 7;
    localparam int unsigned ST_AUX_ONE_POS   = 6;
    localparam int unsigned ST_AUX_TWO_POS   = 5;
    localparam int unsigned ST_ILLUM_ONE_POS = 3;
    localparam int unsigned ST_ILLUM_TWO_POS = 2;
    localparam logic [7:0]  PG_USED_MASK     = 8'he0 | 8'h0c;
    localparam logic [7:0]  OV_USED_MASK     = 8'he0 | 8'h0c;

    // Wheel drive transfer: 0x0000 is 0 V, 0xFFFF is 5 V
    localparam real WHEEL_STEP_UV = 76.294;

endpackage : led_regs_pkg

// file: fault_flag_bank.sv
module fault_flag_bank #(
    parameter int unsigned WIDTH     = 8,
    parameter logic [7:0]  USED_MASK = 8'hff
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] fault_raw_i,
    input  wire logic             clear_i,
    output logic      [WIDTH-1:0] flags_o
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] flags_r;
    logic [WIDTH-1:0] flags_nxt;

    // Set beats clear so a fault landing on the read is kept
    always_comb begin
        flags_nxt = flags_r;
        if (clear_i) begin
            flags_nxt = '0;
        end
        flags_nxt = (flags_nxt | sync_r) & USED_MASK[WIDTH-1:0];
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta_r  <= '0;
            sync_r  <= '0;
            flags_r <= '0;
        end else begin
            meta_r  <= fault_raw_i;
            sync_r  <= meta_r;
            flags_r <= flags_nxt;
        end
    end

    assign flags_o = flags_r;

endmodule : fault_flag_bank

// file: led_pmic_status_capability_regs.sv
module led_pmic_status_capability_regs (
    input  wire logic        CLOCK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        SPI_SCLK_I,
    input  wire logic        SPI_CS_N_I,
    input  wire logic        SPI_MOSI_I,
    input  wire logic        FOCUS_CONV_POWER_FAIL_I,
    input  wire logic        AUX_CONV_ONE_POWER_FAIL_I,
    input  wire logic        AUX_CONV_TWO_POWER_FAIL_I,
    input  wire logic        ILLUM_CONV_ONE_POWER_FAIL_I,
    input  wire logic        ILLUM_CONV_TWO_POWER_FAIL_I,
    input  wire logic        FOCUS_CONV_OVERVOLTAGE_I,
    input  wire logic        AUX_CONV_ONE_OVERVOLTAGE_I,
    input  wire logic        AUX_CONV_TWO_OVERVOLTAGE_I,
    input  wire logic        ILLUM_CONV_ONE_OVERVOLTAGE_I,
    input  wire logic        ILLUM_CONV_TWO_OVERVOLTAGE_I,
    output logic             SPI_MISO_O,
    output logic             SPI_MISO_OE_O,
    output logic      [15:0] WHEEL_DRIVE_LEVEL_O,
    output logic      [1:0]  ILLUM_CONV_ONE_BANDWIDTH_O,
    output logic      [1:0]  ILLUM_CONV_TWO_BANDWIDTH_O,
    output logic             CONVERTER_FAULT_O
);

    // Pin synchronisers
    logic       sclk_meta_r;
    logic       sclk_sync_r;
    logic       sclk_prev_r;
    logic       cs_n_meta_r;
    logic       cs_n_sync_r;
    logic       mosi_meta_r;
    logic       mosi_sync_r;

    // Serial engine state
    logic [4:0] bit_cnt_r;
    logic [4:0] bit_cnt_nxt;
    logic [6:0] shift_in_r;
    logic [6:0] shift_in_nxt;
    logic [6:0] addr_r;
    logic [6:0] addr_nxt;
    logic       is_write_r;
    logic       is_write_nxt;
    logic [7:0] shift_out_r;
    logic [7:0] shift_out_nxt;
    logic       miso_r;
    logic       miso_nxt;
    logic       miso_oe_r;
    logic       miso_oe_nxt;

    // Register file state
    logic [7:0] wheel_low_r;
    logic [7:0] wheel_low_nxt;
    logic [7:0] wheel_high_r;
    logic [7:0] wheel_high_nxt;
    logic [3:0] bandwidth_r;
    logic [3:0] bandwidth_nxt;
    logic [7:0] capability_r;
    logic [7:0] cap_bits;
    logic       fault_any_r;
    logic       fault_any_nxt;

    // Status flags and their read-clear strobes
    logic [7:0] pg_flags;
    logic [7:0] ov_flags;
    logic [7:0] pg_raw;
    logic [7:0] ov_raw;
    logic       pg_clear;
    logic       ov_clear;

    logic       sclk_rise;
    logic       sclk_fall;
    logic       frame_open;
    logic [7:0] cmd_byte;
    logic [7:0] data_byte;

    function automatic logic [7:0] read_value(
        input logic [6:0] addr,
        input logic [7:0] low,
        input logic [7:0] high,
        input logic [3:0] bw,
        input logic [7:0] cap,
        input logic [7:0] pg,
        input logic [7:0] ov
    );
        logic [7:0] value;
        value = led_regs_pkg::UNMAPPED_READ;
        case (addr)
            led_regs_pkg::ADDR_WHEEL_LOW: begin
                value = low;
            end
            led_regs_pkg::ADDR_WHEEL_HIGH: begin
                value = high;
            end
            led_regs_pkg::ADDR_BANDWIDTH: begin
                // Upper nibble reserved, reads zero
                value = {4'h0, bw};
            end
            led_regs_pkg::ADDR_CAPABILITY: begin
                value = cap;
            end
            led_regs_pkg::ADDR_PG_STATUS: begin
                value = pg;
            end
            led_regs_pkg::ADDR_OV_STATUS: begin
                value = ov;
            end
            default: begin
                value = led_regs_pkg::UNMAPPED_READ;
            end
        endcase
        return value;
    endfunction : read_value

    assign pg_raw[led_regs_pkg::ST_FOCUS_POS]     = FOCUS_CONV_POWER_FAIL_I;
    assign pg_raw[led_regs_pkg::ST_AUX_ONE_POS]   = AUX_CONV_ONE_POWER_FAIL_I;
    assign pg_raw[led_regs_pkg::ST_AUX_TWO_POS]   = AUX_CONV_TWO_POWER_FAIL_I;
    assign pg_raw[led_regs_pkg::ST_ILLUM_ONE_POS] = ILLUM_CONV_ONE_POWER_FAIL_I;
    assign pg_raw[led_regs_pkg::ST_ILLUM_TWO_POS] = ILLUM_CONV_TWO_POWER_FAIL_I;
    assign pg_raw[4]   = 1'b0;
    assign pg_raw[1:0] = 2'b00;

    assign ov_raw[led_regs_pkg::ST_FOCUS_POS]     = FOCUS_CONV_OVERVOLTAGE_I;
    assign ov_raw[led_regs_pkg::ST_AUX_ONE_POS]   = AUX_CONV_ONE_OVERVOLTAGE_I;
    assign ov_raw[led_regs_pkg::ST_AUX_TWO_POS]   = AUX_CONV_TWO_OVERVOLTAGE_I;
    assign ov_raw[led_regs_pkg::ST_ILLUM_ONE_POS] = ILLUM_CONV_ONE_OVERVOLTAGE_I;
    assign ov_raw[led_regs_pkg::ST_ILLUM_TWO_POS] = ILLUM_CONV_TWO_OVERVOLTAGE_I;
    assign ov_raw[4]   = 1'b0;
    assign ov_raw[1:0] = 2'b00;

    // Build options, one bit each, fixed for this part
    // auto LED off
    assign cap_bits[led_regs_pkg::CAP_AUTO_LED_OFF_POS] =
        led_regs_pkg::CAPABILITY_RESET[led_regs_pkg::CAP_AUTO_LED_OFF_POS];
    assign cap_bits[led_regs_pkg::CAP_EXT_SWITCH_POS] =
        led_regs_pkg::CAPABILITY_RESET[led_regs_pkg::CAP_EXT_SWITCH_POS];
    assign cap_bits[led_regs_pkg::CAP_WHEEL_POS] =
        led_regs_pkg::CAPABILITY_RESET[led_regs_pkg::CAP_WHEEL_POS];
    // Reserved bit 4 keeps the value given
    assign cap_bits[4] = led_regs_pkg::CAPABILITY_RESET[4];
    assign cap_bits[led_regs_pkg::CAP_REG_ONE_MIRROR_POS] =
        led_regs_pkg::CAPABILITY_RESET[led_regs_pkg::CAP_REG_ONE_MIRROR_POS];
    assign cap_bits[led_regs_pkg::CAP_REG_TWO_MIRROR_POS] =
        led_regs_pkg::CAPABILITY_RESET[led_regs_pkg::CAP_REG_TWO_MIRROR_POS];
    assign cap_bits[led_regs_pkg::CAP_MIRROR_CONV_ONE_POS] =
        led_regs_pkg::CAPABILITY_RESET[led_regs_pkg::CAP_MIRROR_CONV_ONE_POS];
    assign cap_bits[led_regs_pkg::CAP_MIRROR_CONV_TWO_POS] =
        led_regs_pkg::CAPABILITY_RESET[led_regs_pkg::CAP_MIRROR_CONV_TWO_POS];

    fault_flag_bank #(
        .WIDTH     (8),
        .USED_MASK (led_regs_pkg::PG_USED_MASK)
    ) u_pg_flags (
        .clock_i     (CLOCK_I),
        .reset_i     (SYS_RST_I),
        .fault_raw_i (pg_raw),
        .clear_i     (pg_clear),
        .flags_o     (pg_flags)
    );

    fault_flag_bank #(
        .WIDTH     (8),
        .USED_MASK (led_regs_pkg::OV_USED_MASK)
    ) u_ov_flags (
        .clock_i     (CLOCK_I),
        .reset_i     (SYS_RST_I),
        .fault_raw_i (ov_raw),
        .clear_i     (ov_clear),
        .flags_o     (ov_flags)
    );

    assign sclk_rise  = sclk_sync_r & ~sclk_prev_r;
    assign sclk_fall  = ~sclk_sync_r & sclk_prev_r;
    assign frame_open = ~cs_n_sync_r;
    assign cmd_byte   = {shift_in_r, mosi_sync_r};
    assign data_byte  = {shift_in_r, mosi_sync_r};

    always_comb begin
        bit_cnt_nxt   = bit_cnt_r;
        shift_in_nxt  = shift_in_r;
        addr_nxt      = addr_r;
        is_write_nxt  = is_write_r;
        shift_out_nxt = shift_out_r;
        miso_nxt      = miso_r;
        miso_oe_nxt   = miso_oe_r;
        pg_clear      = 1'b0;
        ov_clear      = 1'b0;
        if (!frame_open) begin
            // Deselect aborts any partial frame
            bit_cnt_nxt = 5'h00;
            miso_oe_nxt = 1'b0;
            miso_nxt    = 1'b0;
        end else begin
            if (sclk_rise && bit_cnt_r != led_regs_pkg::FRAME_END) begin
                bit_cnt_nxt  = bit_cnt_r + 5'h01;
                shift_in_nxt = {shift_in_r[5:0], mosi_sync_r};
                if (bit_cnt_r == led_regs_pkg::CMD_LAST_BIT) begin
                    addr_nxt     = cmd_byte[6:0];
                    is_write_nxt = cmd_byte[led_regs_pkg::CMD_WRITE_POS];
                    shift_out_nxt = read_value(cmd_byte[6:0], wheel_low_r,
                        wheel_high_r, bandwidth_r, capability_r,
                        pg_flags, ov_flags);
                    // Status clears only on a read that sampled it
                    if (!cmd_byte[led_regs_pkg::CMD_WRITE_POS]) begin
                        pg_clear = cmd_byte[6:0] ==
                                   led_regs_pkg::ADDR_PG_STATUS;
                        ov_clear = cmd_byte[6:0] ==
                                   led_regs_pkg::ADDR_OV_STATUS;
                    end
                end
            end
            if (sclk_fall && !is_write_r &&
                bit_cnt_r >= led_regs_pkg::CMD_LAST_BIT + 5'h01 &&
                bit_cnt_r <= led_regs_pkg::DATA_LAST_BIT) begin
                miso_nxt      = shift_out_r[7];
                shift_out_nxt = {shift_out_r[6:0], 1'b0};
                miso_oe_nxt   = 1'b1;
            end
        end
    end

    always_comb begin
        wheel_low_nxt  = wheel_low_r;
        wheel_high_nxt = wheel_high_r;
        bandwidth_nxt  = bandwidth_r;
        if (frame_open && sclk_rise && is_write_r &&
            bit_cnt_r == led_regs_pkg::DATA_LAST_BIT) begin
            case (addr_r)
                led_regs_pkg::ADDR_WHEEL_LOW: begin
                    wheel_low_nxt = data_byte;
                end
                led_regs_pkg::ADDR_WHEEL_HIGH: begin
                    wheel_high_nxt = data_byte;
                end
                led_regs_pkg::ADDR_BANDWIDTH: begin
                    bandwidth_nxt = data_byte[3:0];
                end
                default: begin
                    wheel_low_nxt = wheel_low_r;
                end
            endcase
        end
    end

    // warning level only, no shutdown path
    always_comb begin
        fault_any_nxt = (|pg_flags) | (|ov_flags);
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            sclk_meta_r <= 1'b0;
            sclk_sync_r <= 1'b0;
            sclk_prev_r <= 1'b0;
            cs_n_meta_r <= 1'b1;
            cs_n_sync_r <= 1'b1;
            mosi_meta_r <= 1'b0;
            mosi_sync_r <= 1'b0;
        end else begin
            sclk_meta_r <= SPI_SCLK_I;
            sclk_sync_r <= sclk_meta_r;
            sclk_prev_r <= sclk_sync_r;
            cs_n_meta_r <= SPI_CS_N_I;
            cs_n_sync_r <= cs_n_meta_r;
            mosi_meta_r <= SPI_MOSI_I;
            mosi_sync_r <= mosi_meta_r;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            bit_cnt_r   <= 5'h00;
            shift_in_r  <= 7'h00;
            addr_r      <= 7'h00;
            is_write_r  <= 1'b0;
            shift_out_r <= 8'h00;
            miso_r      <= 1'b0;
            miso_oe_r   <= 1'b0;
        end else begin
            bit_cnt_r   <= bit_cnt_nxt;
            shift_in_r  <= shift_in_nxt;
            addr_r      <= addr_nxt;
            is_write_r  <= is_write_nxt;
            shift_out_r <= shift_out_nxt;
            miso_r      <= miso_nxt;
            miso_oe_r   <= miso_oe_nxt;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            wheel_low_r  <= led_regs_pkg::WHEEL_LOW_RESET;
            wheel_high_r <= led_regs_pkg::WHEEL_HIGH_RESET;
            bandwidth_r  <= led_regs_pkg::BANDWIDTH_RESET;
            capability_r <= cap_bits;
            fault_any_r  <= 1'b0;
        end else begin
            wheel_low_r  <= wheel_low_nxt;
            wheel_high_r <= wheel_high_nxt;
            bandwidth_r  <= bandwidth_nxt;
            capability_r <= capability_r;
            fault_any_r  <= fault_any_nxt;
        end
    end

    // straight code to analog stage, 76.294 uV per code
    assign WHEEL_DRIVE_LEVEL_O = {wheel_high_r, wheel_low_r};
    // codes passed raw to the loop compensation
    assign ILLUM_CONV_ONE_BANDWIDTH_O =
        bandwidth_r[led_regs_pkg::BW_ONE_LSB +: led_regs_pkg::BW_WIDTH];
    assign ILLUM_CONV_TWO_BANDWIDTH_O =
        bandwidth_r[led_regs_pkg::BW_TWO_LSB +: led_regs_pkg::BW_WIDTH];
    assign SPI_MISO_O        = miso_r;
    assign SPI_MISO_OE_O     = miso_oe_r;
    assign CONVERTER_FAULT_O = fault_any_r;

endmodule : led_pmic_status_capability_regs

// file: led_regs_monitor.sv
module led_regs_monitor (
    input  wire logic        CLOCK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        SPI_CS_N_I,
    input  wire logic        FOCUS_CONV_POWER_FAIL_I,
    input  wire logic        AUX_CONV_ONE_POWER_FAIL_I,
    input  wire logic        AUX_CONV_TWO_POWER_FAIL_I,
    input  wire logic        ILLUM_CONV_ONE_POWER_FAIL_I,
    input  wire logic        ILLUM_CONV_TWO_POWER_FAIL_I,
    input  wire logic        FOCUS_CONV_OVERVOLTAGE_I,
    input  wire logic        AUX_CONV_ONE_OVERVOLTAGE_I,
    input  wire logic        AUX_CONV_TWO_OVERVOLTAGE_I,
    input  wire logic        ILLUM_CONV_ONE_OVERVOLTAGE_I,
    input  wire logic        ILLUM_CONV_TWO_OVERVOLTAGE_I,
    input  wire logic        SPI_MISO_OE_O,
    input  wire logic [15:0] WHEEL_DRIVE_LEVEL_O,
    input  wire logic [1:0]  ILLUM_CONV_ONE_BANDWIDTH_O,
    input  wire logic [1:0]  ILLUM_CONV_TWO_BANDWIDTH_O,
    input  wire logic        CONVERTER_FAULT_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ov_any;
    logic any_fault;
    assign ov_any = FOCUS_CONV_OVERVOLTAGE_I | AUX_CONV_ONE_OVERVOLTAGE_I
                  | AUX_CONV_TWO_OVERVOLTAGE_I | ILLUM_CONV_ONE_OVERVOLTAGE_I
                  | ILLUM_CONV_TWO_OVERVOLTAGE_I;
    assign any_fault = ov_any | FOCUS_CONV_POWER_FAIL_I
                     | AUX_CONV_ONE_POWER_FAIL_I | AUX_CONV_TWO_POWER_FAIL_I
                     | ILLUM_CONV_ONE_POWER_FAIL_I
                     | ILLUM_CONV_TWO_POWER_FAIL_I;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_held(x);
        x [*2];
    endsequence
    // No frame long enough for every synchroniser to settle
    sequence s_idle;
        SPI_CS_N_I [*8];
    endsequence
    a_reset_zero: assert property (disable iff (1'b0) SYS_RST_I |=>
        WHEEL_DRIVE_LEVEL_O == 16'h0000 && !CONVERTER_FAULT_O && !SPI_MISO_OE_O
        && ILLUM_CONV_ONE_BANDWIDTH_O == 2'h0
        && ILLUM_CONV_TWO_BANDWIDTH_O == 2'h0) else $error("reset state");
    a_oe_idle: assert property (s_idle |-> !SPI_MISO_OE_O)
        else $error("MISO driven outside a frame");
    a_wheel_hold: assert property (s_idle |->
        $stable(WHEEL_DRIVE_LEVEL_O))
        else $error("wheel level moved without a frame");
    a_bw_hold: assert property (s_idle |->
        $stable({ILLUM_CONV_ONE_BANDWIDTH_O, ILLUM_CONV_TWO_BANDWIDTH_O}))
        else $error("bandwidth moved idle");
    a_focus_pg: assert property (s_held(FOCUS_CONV_POWER_FAIL_I)
        |-> ##[1:8] CONVERTER_FAULT_O) else $error("focus fault lost");
    a_aux_pg: assert property (s_held(AUX_CONV_ONE_POWER_FAIL_I
        | AUX_CONV_TWO_POWER_FAIL_I) |-> ##[1:8] CONVERTER_FAULT_O)
        else $error("aux fault lost");
    a_illum_pg: assert property (s_held(ILLUM_CONV_ONE_POWER_FAIL_I
        | ILLUM_CONV_TWO_POWER_FAIL_I) |-> ##[1:8] CONVERTER_FAULT_O)
        else $error("illum fault lost");
    a_ov_fault: assert property (s_held(ov_any) |->
        ##[1:8] CONVERTER_FAULT_O) else $error("overvoltage fault lost");
    a_fault_sticky: assert property (s_idle ##0 CONVERTER_FAULT_O
        |=> CONVERTER_FAULT_O) else $error("fault flag dropped unread");
    a_fault_cause: assert property ($rose(CONVERTER_FAULT_O) |->
        $past(any_fault, 2) || $past(any_fault, 3) || $past(any_fault, 4)
        || $past(any_fault, 5) || $past(any_fault, 6))
        else $error("fault flag without cause");
endmodule : led_regs_monitor

bind led_pmic_status_capability_regs led_regs_monitor i_mon (.*);

// file: host_model.sv
module host_model (
    input  wire logic       clk_i,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic            mosi_o,
    input  wire logic       miso_i,
    input  wire logic       miso_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask : tick
    // Ten clocks per phase keeps both SCLK phases above eight
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] f;
        f = {cmd, wd};
        rd = 8'h00;
        cs_n_o = 1'b0;
        tick(10);
        for (int i = 15; i >= 0; i--) begin
            mosi_o = f[i];
            tick(10);
            sclk_o = 1'b1;
            // Undriven line must not pass for data
            if (i < 8) rd = {rd[6:0], miso_oe_i ? miso_i : 1'bx};
            tick(10);
            sclk_o = 1'b0;
        end
        tick(10);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        tick(12);
    endtask : xfer
endmodule : host_model

// file: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sclk, cs_n, mosi, miso, miso_oe, cfault;
    logic [9:0]  flt = 10'h000;
    logic [15:0] wheel;
    logic [1:0]  bw1, bw2;
    int          errors = 0;
    int          n_checks = 0;
    always #2 clk = ~clk;
    led_pmic_status_capability_regs i_dut (.CLOCK_I(clk), .SYS_RST_I(rst),
        .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n), .SPI_MOSI_I(mosi),
        .FOCUS_CONV_POWER_FAIL_I(flt[0]), .AUX_CONV_ONE_POWER_FAIL_I(flt[1]),
        .AUX_CONV_TWO_POWER_FAIL_I(flt[2]),
        .ILLUM_CONV_ONE_POWER_FAIL_I(flt[3]),
        .ILLUM_CONV_TWO_POWER_FAIL_I(flt[4]),
        .FOCUS_CONV_OVERVOLTAGE_I(flt[5]), .AUX_CONV_ONE_OVERVOLTAGE_I(flt[6]),
        .AUX_CONV_TWO_OVERVOLTAGE_I(flt[7]),
        .ILLUM_CONV_ONE_OVERVOLTAGE_I(flt[8]),
        .ILLUM_CONV_TWO_OVERVOLTAGE_I(flt[9]), .SPI_MISO_O(miso),
        .SPI_MISO_OE_O(miso_oe), .WHEEL_DRIVE_LEVEL_O(wheel),
        .ILLUM_CONV_ONE_BANDWIDTH_O(bw1), .ILLUM_CONV_TWO_BANDWIDTH_O(bw2),
        .CONVERTER_FAULT_O(cfault));
    host_model i_host (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
        .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error t=%0t %s got %h exp %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_host.xfer({1'b1, a}, d, r);
    endtask : wr
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        i_host.xfer({1'b0, a}, 8'h00, r);
        check({8'h00, r}, {8'h00, exp}, "register read");
    endtask : rdchk
    task automatic t_reset();
        check(wheel, 16'h0000, "wheel after reset");
        check({12'h000, bw1, bw2}, 16'h0000, "bandwidth after reset");
        rdchk(led_regs_pkg::ADDR_WHEEL_HIGH, 8'h00);
        rdchk(led_regs_pkg::ADDR_WHEEL_LOW, 8'h00);
        rdchk(led_regs_pkg::ADDR_BANDWIDTH, 8'h00);
        // Capability bits 7..0 all fixed in one value
        rdchk(led_regs_pkg::ADDR_CAPABILITY, 8'hdf);
        rdchk(led_regs_pkg::ADDR_PG_STATUS, 8'h00);
        rdchk(led_regs_pkg::ADDR_OV_STATUS, 8'h00);
    endtask : t_reset
    task automatic t_wheel();
        wr(led_regs_pkg::ADDR_WHEEL_HIGH, 8'hab);
        wr(led_regs_pkg::ADDR_WHEEL_LOW, 8'h01);
        check(wheel, 16'hab01, "wheel level split");
        rdchk(led_regs_pkg::ADDR_WHEEL_HIGH, 8'hab);
        wr(led_regs_pkg::ADDR_WHEEL_HIGH, 8'hff);
        wr(led_regs_pkg::ADDR_WHEEL_LOW, 8'hff);
        check(wheel, 16'hffff, "wheel full scale");
        wr(led_regs_pkg::ADDR_WHEEL_HIGH, 8'h00);
        check(wheel, 16'h00ff, "wheel high only");
        rdchk(led_regs_pkg::ADDR_WHEEL_LOW, 8'hff);
    endtask : t_wheel
    task automatic t_bandwidth();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(led_regs_pkg::ADDR_BANDWIDTH, {4'hf, c, ~c});
            check({14'h0000, bw1}, {14'h0000, c}, "bandwidth one");
            check({14'h0000, bw2}, {14'h0000, ~c}, "bandwidth two");
            rdchk(led_regs_pkg::ADDR_BANDWIDTH, {4'h0, c, ~c});
        end
    endtask : t_bandwidth
    task automatic t_ro_writes();
        wr(led_regs_pkg::ADDR_CAPABILITY, 8'h00);
        wr(led_regs_pkg::ADDR_PG_STATUS, 8'hff);
        wr(led_regs_pkg::ADDR_OV_STATUS, 8'hff);
        wr(7'h7f, 8'h5a);
        rdchk(led_regs_pkg::ADDR_CAPABILITY, 8'hdf);
        rdchk(led_regs_pkg::ADDR_PG_STATUS, 8'h00);
        rdchk(led_regs_pkg::ADDR_OV_STATUS, 8'h00);
        rdchk(7'h7f, 8'h00);
        check({15'h0000, cfault}, 16'h0000, "no fault side effect");
        check(wheel, 16'h00ff, "no wheel side effect");
    endtask : t_ro_writes
    task automatic t_faults();
        int pos [5] = '{7, 6, 5, 3, 2};
        logic [6:0] a;
        for (int i = 0; i < 10; i++) begin
            a = (i < 5) ? led_regs_pkg::ADDR_PG_STATUS
                        : led_regs_pkg::ADDR_OV_STATUS;
            flt[i] = 1'b1;
            i_host.tick(4);
            flt[i] = 1'b0;
            i_host.tick(8);
            check({15'h0000, cfault}, 16'h0001, "fault flag raised");
            // One bit each, reserved bits stay clear
            rdchk(a, 8'h01 << pos[i % 5]);
            rdchk(a, 8'h00);
            check({15'h0000, cfault}, 16'h0000, "fault flag cleared");
        end
    endtask : t_faults
    task automatic conclude();
        $display("Checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        // About fifty frames of some 350 clocks, with margin
        #120000;
        errors++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        i_host.tick(4);
        t_reset();
        t_wheel();
        t_bandwidth();
        t_ro_writes();
        t_faults();
        conclude();
    end
endmodule : tb_top
